// ===== verilog/ccpc_pkg.sv
// Package for the channel enable and power control register bank.
// Assumes one 10 MHz system clock and a byte-wide register port fed by the control bus decoder.
package ccpc_pkg;

    // Channel count and register width
    localparam int CCPC_NCH = 8;
    localparam int CCPC_DW = 8;
    localparam int CCPC_AW = 8;

    // Register addresses on page zero
    localparam logic [7:0] CCPC_ADDR_INPUT_CHANNEL_ENABLES = 8'h73;
    localparam logic [7:0] CCPC_ADDR_SERIAL_OUTPUT_SLOT_ENABLES = 8'h74;
    localparam logic [7:0] CCPC_ADDR_POWER_CONFIGURATION = 8'h75;
    localparam logic [7:0] CCPC_ADDR_CHANNEL_POWER_STATUS = 8'h76;

    // Values after reset, and the value read from unmapped addresses
    localparam logic [7:0] CCPC_RST_INPUT_CHANNEL_ENABLES = 8'hf0;
    localparam logic [7:0] CCPC_RST_SERIAL_OUTPUT_SLOT_ENABLES = 8'h00;
    localparam logic [7:0] CCPC_RST_POWER_CONFIGURATION = 8'h00;
    localparam logic [7:0] CCPC_RST_CHANNEL_POWER_STATUS = 8'h00;
    localparam logic [7:0] CCPC_RST_READ_DATA = 8'h00;
    localparam logic [7:0] CCPC_UNMAPPED_READ = 8'h00;

    // Field positions of the power configuration register
    localparam int CCPC_MIC_BIAS_POWER_ON_BIT = 7;
    localparam int CCPC_CONVERTER_POWER_ON_BIT = 6;
    localparam int CCPC_PLL_POWER_ON_BIT = 5;
    localparam int CCPC_DYNAMIC_MODE_BIT = 4;
    localparam int CCPC_DYNAMIC_RANGE_MSB = 3;
    localparam int CCPC_DYNAMIC_RANGE_LSB = 2;
    localparam int CCPC_RESERVED_MSB = 1;
    localparam int CCPC_RESERVED_LSB = 0;

    // Digital-microphone-only channels occupy the low nibble
    localparam logic [7:0] CCPC_DMIC_ONLY_MASK = 8'h0f;

    // Dynamic channel range encodings
    typedef enum logic [1:0] {
        CCPC_RANGE_1_2 = 2'h0,
        CCPC_RANGE_1_4 = 2'h1,
        CCPC_RANGE_1_6 = 2'h2,
        CCPC_RANGE_1_8 = 2'h3
    } ccpc_range_t;

endpackage : ccpc_pkg

// ===== verilog/ccpc_chan_power.sv
// Per-channel power controller: decides which converter channels are powered.
// Assumes enables and power bits come from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ccpc_chan_power
#(
    parameter int NCH = ccpc_pkg::CCPC_NCH
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Configuration
    input wire logic converter_power_on,
    input wire logic dynamic_channel_power_mode,
    input wire logic [1:0] dynamic_channel_range,
    input wire logic [NCH-1:0] channel_enables,
    // Power state, channel 1 in the top bit
    output logic [NCH-1:0] chan_powered
);
    import ccpc_pkg::*;

    logic [NCH-1:0] chan_powered_next;
    logic recording;
    logic [3:0] range_top;

    // Any powered channel means a recording is running
    assign recording = |chan_powered;

    // Highest channel number covered by the dynamic range
    always_comb
    begin
        unique case (ccpc_range_t'(dynamic_channel_range))
            CCPC_RANGE_1_2: range_top = 4'h2;
            CCPC_RANGE_1_4: range_top = 4'h4;
            CCPC_RANGE_1_6: range_top = 4'h6;
            CCPC_RANGE_1_8: range_top = 4'h8;
        endcase
    end

    // Next power state per channel
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++)
        begin : g_chan
            localparam logic [3:0] CHAN_NUM = 4'(NCH - gi);
            always_comb
            begin
                if (!converter_power_on)
                    chan_powered_next[gi] = 1'b0;
                else if (!recording)
                    chan_powered_next[gi] = channel_enables[gi];
                else if (dynamic_channel_power_mode && (CHAN_NUM <= range_top))
                    // Host keeps channel 1 up here, so the recording never stalls
                    chan_powered_next[gi] = channel_enables[gi];
                else
                    // Frozen set: enable changes wait for a converter power cycle
                    chan_powered_next[gi] = chan_powered[gi];
            end
        end
    endgenerate

    // Power state register
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            chan_powered <= ccpc_pkg::CCPC_RST_CHANNEL_POWER_STATUS;
        else
            chan_powered <= chan_powered_next;
    end

endmodule : ccpc_chan_power
`default_nettype wire

// ===== verilog/ccpc_regs.sv
// Channel enable and power control register bank with serial slot drive control.
// Assumes a byte-wide register port from the control bus decoder and a slot serializer,
// both on clk_sys at 10 MHz.
//
// Operation
// - Eight read/write input enables, channel 1 at bit 7; channels 1-4 reset enabled.
// - Channels 5-8 are microphone-only and their enables reset to zero.
// - A zero slot enable leaves that output slot undriven; one drives it.
// - Slot enable register maps channel 1 to bit 7, all read/write, reset zero.
// - Power bit 7 turns the microphone bias generator on when set, off when clear.
// - Power bit 6 clear powers all channels down; set powers up enabled channels only.
// - Power bit 5 turns the PLL on when set, off when clear; resets to zero.
// - Without dynamic mode, channel power changes are not applied while recording.
// - With dynamic mode, channels in the dynamic range power up or down individually during recording.
// - Bits 3-2 pick the dynamic range: channels 1-2, 1-4, 1-6 or 1-8.
// - Read-only status register at 0x76, one bit per channel, reset zero.
// - A status bit reads one when its channel is powered, zero otherwise.
`timescale 1ns/100ps
`default_nettype none
module ccpc_regs
#(
    parameter int NCH = ccpc_pkg::CCPC_NCH
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register port from the control bus decoder
    input wire logic [ccpc_pkg::CCPC_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [ccpc_pkg::CCPC_DW-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [ccpc_pkg::CCPC_DW-1:0] reg_rdata,
    output logic reg_rvalid,
    // Slot serializer side of the audio serial port
    input wire logic [2:0] slot_index,
    input wire logic slot_active,
    input wire logic slot_bit,
    // Audio serial port data pin, three signals
    input wire logic sdout_in,
    output logic sdout_out,
    output logic sdout_oe,
    // Power controls to the analog side
    output logic mic_bias_power_on,
    output logic pll_power_on,
    output logic [NCH-1:0] chan_power_en,
    output logic converter_active
);
    import ccpc_pkg::*;

    // Register storage
    logic [CCPC_DW-1:0] input_channel_enables_reg;
    logic [CCPC_DW-1:0] serial_output_slot_enables_reg;
    logic [CCPC_DW-1:0] power_configuration_reg;
    logic [CCPC_DW-1:0] reg_rdata_next;
    logic [NCH-1:0] chan_powered;

    // Decoded write strobes
    logic wr_in_en;
    logic wr_slot_en;
    logic wr_power_configuration;

    // Field views of the power configuration register
    logic converter_power_on;
    logic dynamic_channel_power_mode;
    logic [1:0] dynamic_channel_range;

    // Slot drive decode
    logic slot_drive_sel;

    // Address decode; status register has no write strobe at all
    assign wr_in_en = reg_wr && (reg_addr == CCPC_ADDR_INPUT_CHANNEL_ENABLES);
    assign wr_slot_en = reg_wr && (reg_addr == CCPC_ADDR_SERIAL_OUTPUT_SLOT_ENABLES);
    assign wr_power_configuration = reg_wr && (reg_addr == CCPC_ADDR_POWER_CONFIGURATION);

    // Field extraction
    assign converter_power_on = power_configuration_reg[CCPC_CONVERTER_POWER_ON_BIT];
    assign dynamic_channel_power_mode = power_configuration_reg[CCPC_DYNAMIC_MODE_BIT];
    assign dynamic_channel_range =
        power_configuration_reg[CCPC_DYNAMIC_RANGE_MSB:CCPC_DYNAMIC_RANGE_LSB];

    // Input channel enables, channel 1 in bit 7
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            input_channel_enables_reg <= CCPC_RST_INPUT_CHANNEL_ENABLES;
        else if (wr_in_en)
            input_channel_enables_reg <= reg_wdata;
    end

    // Serial output slot enables, channel 1 in bit 7
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            serial_output_slot_enables_reg <= CCPC_RST_SERIAL_OUTPUT_SLOT_ENABLES;
        else if (wr_slot_en)
            serial_output_slot_enables_reg <= reg_wdata;
    end

    // Power configuration; reserved low bits simply hold what was written
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            power_configuration_reg <= CCPC_RST_POWER_CONFIGURATION;
        else if (wr_power_configuration)
            power_configuration_reg <= reg_wdata;
    end

    // Per-channel power decision
    ccpc_chan_power #(
        .NCH(NCH)
    ) u_chan_power (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .converter_power_on(converter_power_on),
        .dynamic_channel_power_mode(dynamic_channel_power_mode),
        .dynamic_channel_range(dynamic_channel_range),
        .channel_enables(input_channel_enables_reg[NCH-1:0]),
        .chan_powered(chan_powered)
    );

    // Channel power enables follow the controller's register directly
    assign chan_power_en = chan_powered;

    // Bias and PLL switches; registered so the analog pins never see decode glitches
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            mic_bias_power_on <= 1'b0;
            pll_power_on <= 1'b0;
        end
        else
        begin
            mic_bias_power_on <= power_configuration_reg[CCPC_MIC_BIAS_POWER_ON_BIT];
            pll_power_on <= power_configuration_reg[CCPC_PLL_POWER_ON_BIT];
        end
    end

    // Converter activity summary, one cycle behind the channel state
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            converter_active <= 1'b0;
        else
            converter_active <= |chan_powered;
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb
    begin
        unique case (reg_addr)
            CCPC_ADDR_INPUT_CHANNEL_ENABLES: reg_rdata_next = input_channel_enables_reg;
            CCPC_ADDR_SERIAL_OUTPUT_SLOT_ENABLES: reg_rdata_next = serial_output_slot_enables_reg;
            CCPC_ADDR_POWER_CONFIGURATION: reg_rdata_next = power_configuration_reg;
            CCPC_ADDR_CHANNEL_POWER_STATUS: reg_rdata_next = chan_powered;
            default: reg_rdata_next = CCPC_UNMAPPED_READ;
        endcase
    end

    // Read data register; holds its value until the next read
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            reg_rdata <= CCPC_RST_READ_DATA;
        else if (reg_rd)
            reg_rdata <= reg_rdata_next;
    end

    // Read valid pulse, one cycle after the read request
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            reg_rvalid <= 1'b0;
        else
            reg_rvalid <= reg_rd;
    end

    // Slot enable lookup: slot 0 carries channel 1, held in bit 7
    assign slot_drive_sel = serial_output_slot_enables_reg[3'(NCH - 1) - slot_index];

    // Data pin drive; a disabled slot releases the line so another device may share it
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            sdout_out <= 1'b0;
            sdout_oe <= 1'b0;
        end
        else
        begin
            sdout_out <= slot_bit;
            sdout_oe <= slot_active && slot_drive_sel;
        end
    end

    // The pin's input side is not needed here; sharing is decided by the enable alone
    logic unused_sdout_in;
    assign unused_sdout_in = sdout_in;

endmodule : ccpc_regs
`default_nettype wire

// ===== bench/ccpc_regs_assertions.sv
// Checker for the channel power register bank, watching only its top ports.
// Assumes one clock and the synchronous active-low reset of the bank.
`timescale 1ns/100ps
`default_nettype none
module ccpc_regs_assertions
#(
    parameter int NCH = 8
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Serial slot and power side
    input wire logic [2:0] slot_index,
    input wire logic slot_active,
    input wire logic slot_bit,
    input wire logic sdout_out,
    input wire logic sdout_oe,
    input wire logic mic_bias_power_on,
    input wire logic pll_power_on,
    input wire logic [NCH-1:0] chan_power_en,
    input wire logic converter_active
);
    // Shadows of two registers, so outputs are judged without reading the bank back
    logic [7:0] slot_en_reg;
    logic [7:0] cfg_reg;
    always_ff @(posedge clk_sys)
        slot_en_reg <= !rst_b ? 8'h00 : (reg_wr && reg_addr == 8'h74) ? reg_wdata : slot_en_reg;
    always_ff @(posedge clk_sys)
        cfg_reg <= !rst_b ? 8'h00 : (reg_wr && reg_addr == 8'h75) ? reg_wdata : cfg_reg;
    // One domain, so clock and reset are given once
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    a_read_pulse: assert property (reg_rvalid == $past(reg_rd)) else $error("read valid misplaced");
    a_status_live: assert property (reg_rd && reg_addr == 8'h76 |=> reg_rdata == $past(chan_power_en)) else $error("status wrong");
    a_slot_drive: assert property (sdout_oe == $past(slot_active && slot_en_reg[3'd7 - slot_index])) else $error("slot drive wrong");
    a_slot_data: assert property (sdout_oe |-> sdout_out == $past(slot_bit)) else $error("slot data wrong");
    a_bias_follow: assert property (mic_bias_power_on == $past(cfg_reg[7])) else $error("bias wrong");
    a_pll_follow: assert property (pll_power_on == $past(cfg_reg[5])) else $error("pll wrong");
    a_conv_off: assert property (!cfg_reg[6] |=> chan_power_en == '0) else $error("channel left on");
    a_any_active: assert property (converter_active == |$past(chan_power_en)) else $error("activity flag wrong");
endmodule : ccpc_regs_assertions
`default_nettype wire

// ===== bench/ccpc_host.sv
// Host model: single-byte writes and reads on the bank's register port.
// Assumes strobes are taken at a rising edge and read data answers one cycle later.
`timescale 1ns/100ps
`default_nettype none
module ccpc_host
(
    // Clock
    input wire logic clk_sys,
    // Register port toward the bank
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // Idle bus at time zero
    initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h00000;
    // Released lines are inverted so stale values never pass for a live request
    task automatic wr(input logic [7:0] a, input logic [7:0] d); // Writes the byte as given, even one that clears channel 1
        @(negedge clk_sys) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk_sys) {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
    endtask : wr
    // Read gives all unknown when no answer comes within the bound
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        d = 8'hxx;
        @(negedge clk_sys) {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk_sys) {reg_addr, reg_rd} = {~a, 1'b0};
        repeat (2)
            if (reg_rvalid !== 1'b1)
                @(negedge clk_sys);
        if (reg_rvalid === 1'b1)
            d = reg_rdata;
    endtask : rd
endmodule : ccpc_host
`default_nettype wire

// ===== bench/tb_channel_enable_power_control.sv
// Self-checking bench for the channel enable and power control bank.
// Assumes the host model drives the register port on falling edges.
`timescale 1ns/100ps
`default_nettype none
module tb_channel_enable_power_control;
    // Bench signals
    logic clk_sys = 1'b0, rst_b = 1'b0, reg_wr, reg_rd, reg_rvalid, sdout_out, sdout_oe, e;
    logic slot_active = 1'b0, slot_bit = 1'b0, mic_bias_power_on, pll_power_on, converter_active;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, chan_power_en, slot_sel = 8'ha5;
    logic [2:0] slot_index = 3'h0;
    int n_mismatch = 0, num_checks = 0;
    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;
    // Host and bank; the data pin input is unused by the bank
    ccpc_host host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    ccpc_regs dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .slot_index(slot_index),
        .slot_active(slot_active), .slot_bit(slot_bit), .sdout_in(1'b0), .sdout_out(sdout_out),
        .sdout_oe(sdout_oe), .mic_bias_power_on(mic_bias_power_on), .pll_power_on(pll_power_on),
        .chan_power_en(chan_power_en), .converter_active(converter_active));
    // Verdict and end of run
    task automatic conclude();
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    // Compare, count, report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        n_mismatch += int'(got !== exp);
        if (got !== exp)
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    endtask : chk
    // Read and compare; a read that never answers ends the run
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.rd(a, v);
        chk(v, exp);
        if (v === 8'hxx)
            conclude();
    endtask : rchk
    // Write, then let the two-edge power update land
    task automatic wt(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        repeat (2) @(negedge clk_sys);
    endtask : wt
    // Main sequence
    initial
    begin
        repeat (5) @(negedge clk_sys);
        rst_b = 1'b1;
        rchk(8'h73, 8'hf0);
        rchk(8'h74, 8'h00);
        rchk(8'h75, 8'h00);
        rchk(8'h10, 8'h00);
        wt(8'h74, 8'hff);
        wt(8'h73, 8'h0f);
        wt(8'h75, 8'h43);
        wt(8'h76, 8'hff);
        rchk(8'h74, 8'hff);
        rchk(8'h75, 8'h43);
        rchk(8'h76, 8'h0f);
        chk({6'h00, mic_bias_power_on, pll_power_on}, 8'h00);
        // Without dynamic mode, enables wait for a power cycle
        wt(8'h73, 8'hff);
        chk(chan_power_en, 8'h0f);
        wt(8'h75, 8'ha0);
        chk({chan_power_en[7:2], mic_bias_power_on, pll_power_on}, 8'h03);
        chk({7'h00, converter_active}, 8'h00);
        wt(8'h75, 8'h40);
        chk(chan_power_en, 8'hff);
        chk({7'h00, converter_active}, 8'h01);
        // Dynamic mode over every range code, channel 1 kept enabled throughout
        for (int r = 0; r < 4; r++)
        begin
            wt(8'h75, 8'h00);
            wt(8'h73, 8'h80);
            wt(8'h75, 8'h50 | 8'(r << 2));
            wt(8'h73, 8'hff);
            chk(chan_power_en, 8'hff << (6 - 2 * r));
        end
        // Each slot, then idle; pass nine leaves the slot inactive
        wt(8'h74, slot_sel);
        for (int i = 0; i < 9; i++)
        begin
            slot_active = i < 8;
            slot_index = 3'(i);
            slot_bit = i[0];
            e = i < 8 && slot_sel[7 - i];
            @(negedge clk_sys);
            chk({6'h00, sdout_oe, sdout_oe & sdout_out}, {6'h00, e, e & slot_bit});
        end
        conclude();
    end
endmodule : tb_channel_enable_power_control
bind ccpc_regs ccpc_regs_assertions #(.NCH(NCH)) u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .slot_index(slot_index), .slot_active(slot_active), .slot_bit(slot_bit), .sdout_out(sdout_out),
    .sdout_oe(sdout_oe), .mic_bias_power_on(mic_bias_power_on), .pll_power_on(pll_power_on),
    .chan_power_en(chan_power_en), .converter_active(converter_active));
`default_nettype wire
